// [verilog/mux_pkg.sv]
// shared constants and types for the four-line serial multiplexer
package mux_pkg;

  // ****************************************
  // clocking and baud generation
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int NUM_LINES = 4;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_CNT_W = 17;
  localparam int NUM_RATES = 16;
  // rates in tenths of a baud so that 134.5 stays exact
  localparam int BAUD_X10 [NUM_RATES] = '{500, 750, 1100, 1345, 1500,
    3000, 6000, 12000, 18000, 20000, 24000, 36000, 48000, 72000, 96000,
    198000};

  typedef logic [BAUD_CNT_W-1:0] div_tab_type [NUM_RATES];

  // rounded divide keeps every rate well inside 0.3 percent
  function automatic div_tab_type build_div();
    div_tab_type t;
    for (int k = 0; k < NUM_RATES; k++) begin
      t[k] = BAUD_CNT_W'((CLK_HZ * 10 + OVERSAMPLE * BAUD_X10[k] / 2) /
        (OVERSAMPLE * BAUD_X10[k]) - 1);
    end
    return t;
  endfunction

  localparam div_tab_type BAUD_DIV_LAST = build_div();

  // ****************************************
  // bit timing in oversample ticks
  // ****************************************
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [4:0] TX_BIT_LAST = 5'h0f;
  localparam logic [4:0] STOP1_LAST = 5'h0f;
  localparam logic [4:0] STOP15_LAST = 5'h17;
  localparam logic [4:0] STOP2_LAST = 5'h1f;
  localparam logic [1:0] LEN5 = 2'h0;
  localparam logic [2:0] LEN_BASE_LAST = 3'h4;

  // ****************************************
  // silo
  // ****************************************
  localparam int SILO_DEPTH = 8;
  localparam int SILO_W = 14;
  localparam int F_PERR = 8;
  localparam int F_FERR = 9;
  localparam int F_OVR = 10;
  localparam int F_BRK = 11;
  localparam int F_LINE = 12;
  localparam logic [4:0] SILO_ALARM_COUNT = 5'h10;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100,
    RX_WAIT = 3'b101
  } rx_state_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } tx_state_type;

endpackage

// [verilog/silo_if.sv]
// valid/ready carrier between the scanner and the receive silo
`timescale 1ns/1ns
`default_nettype none
interface silo_if #(parameter int WIDTH = 14);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
    output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
    input in_ready, input out_valid, input out_data);
endinterface
`default_nettype wire

// [verilog/rx_silo_fifo.sv]
// receive silo: small synchronous fifo with registered storage
`timescale 1ns/1ns
`default_nettype none
module rx_silo_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  silo_if.fifo s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign s.in_ready = cnt_r != (AW+1)'(DEPTH);
  assign s.out_valid = cnt_r != '0;
  assign s.out_data = mem[rptr_r];

  always_comb begin
    push = s.in_valid && s.in_ready;
    pop = s.out_valid && s.out_ready;
    wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; the count guards every read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_r] <= s.in_data;
    end
  end

  property p_no_push_full;
    @(posedge ref_clk) disable iff (sys_rst)
    cnt_r == (AW+1)'(DEPTH) && !s.out_ready |=>
      cnt_r == (AW+1)'(DEPTH);
  endproperty
  a_no_push_full: assert property (p_no_push_full)
    else $error("silo accepts data while full");
endmodule
`default_nettype wire

// [verilog/quad_async_serial_mux.sv]
// four-line asynchronous serial multiplexer core
// Functional notes
// - four independent asynchronous serial lines toward the terminal side.
// - receiver takes 5 to 8 data bits, one start, at least one stop.
// - format and speed per line; receiver and transmitter share the speed.
// - each receiver can be enabled or disabled by program.
// - receiver holds one finished character while assembling the next.
// - mid-bit sampling tolerates 43.75 percent distortion.
// - stop bit of only half a bit period is accepted.
// - break detected per receiver and shown as a status bit.
// - break on line 3 may request halt or boot, chosen by switches.
// - switches: none off-off, halt on-off, boot off-on, on-on illegal.
// - transmitter sends 5 to 8 bits with optional odd or even parity.
// - stop 1 or 2 bits; for 5-bit characters 1 or 1.5 bits.
// - every transmitter can send a break on command.
// - transmitted edges deviate under 2.5 percent over a character.
// - each line has its own generator with 16 selectable rates.
// - rates 50 to 9600 including 134.5, plus 19800.
// - each rate within 0.3 percent of nominal.
// - alarm off and receive irq on: irq while a character is available.
// - alarm on: irq after 16 entries since the last read, more than the 8-entry silo can take, so it never fires.
// - alarm suppresses receive-done irq, re-armed by a silo read.
// - transmit irq when scanner finds an enabled line with empty buffer.
`timescale 1ns/1ns
`default_nettype none
module quad_async_serial_mux #(
  parameter int LINES = mux_pkg::NUM_LINES,
  parameter int SILO_DEPTH = mux_pkg::SILO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] rx_enable,
  input wire logic [3:0] tx_enable,
  input wire logic [7:0] char_len,
  input wire logic [3:0] stop_long,
  input wire logic [3:0] parity_en,
  input wire logic [3:0] parity_odd,
  input wire logic [15:0] baud_code,
  input wire logic [3:0] tx_break,
  input wire logic tx_wr,
  input wire logic [1:0] tx_wr_line,
  input wire logic [7:0] tx_wr_data,
  output logic [3:0] tx_buf_empty,
  input wire logic rx_ie,
  input wire logic tx_ie,
  input wire logic silo_alarm_en,
  input wire logic rbuf_rd,
  output logic rbuf_valid,
  output logic [1:0] rbuf_line,
  output logic [7:0] rbuf_data,
  output logic rbuf_break,
  output logic rbuf_overrun,
  output logic rbuf_frame_err,
  output logic rbuf_parity_err,
  output logic [3:0] break_status,
  input wire logic [3:0] serial_in,
  output logic [3:0] serial_out,
  input wire logic halt_sw,
  input wire logic boot_sw,
  output logic halt_req,
  output logic boot_req,
  output logic rx_irq,
  output logic tx_irq,
  output logic [1:0] tx_irq_line
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  silo_if #(.WIDTH(mux_pkg::SILO_W)) silo ();
  logic [mux_pkg::SILO_W-1:0] hold_word [4];
  logic [3:0] hold_v;
  logic [1:0] scan_r, scan_nxt;

  // ****************************************
  // per-line receivers and transmitters
  // ****************************************
  for (genvar i = 0; i < 4; i++) begin : g_line
    logic [2:0] sync_r;
    logic lvl_r, lvl_nxt, tick, take, done, wr_hit;
    logic [1:0] len;
    logic [2:0] last;
    logic [7:0] mask;
    logic [mux_pkg::BAUD_CNT_W-1:0] bcnt_r, bcnt_nxt, blast;
    mux_pkg::rx_state_type rst_r, rst_nxt;
    logic [3:0] rph_r, rph_nxt;
    logic [2:0] rbi_r, rbi_nxt;
    logic [7:0] rsh_r, rsh_nxt;
    logic rpb_r, rpb_nxt, hv_r, hv_nxt, brk_r, brk_nxt;
    logic [5:0] hflag_r, hflag_nxt;
    logic [7:0] hd_r, hd_nxt;
    mux_pkg::tx_state_type tst_r, tst_nxt;
    logic [4:0] tph_r, tph_nxt, stop_last;
    logic [2:0] tbi_r, tbi_nxt;
    logic [7:0] tsh_r, tsh_nxt, tbuf_r, tbuf_nxt;
    logic tbv_r, tbv_nxt, out_r, out_nxt;

    assign len = char_len[2*i +: 2];
    assign last = mux_pkg::LEN_BASE_LAST + {1'b0, len};
    assign mask = 8'(8'hff >> (2'h3 - len));
    assign blast = mux_pkg::BAUD_DIV_LAST[baud_code[4*i +: 4]];
    assign tick = bcnt_r >= blast;
    assign take = silo.in_ready && scan_r == 2'(i);
    assign wr_hit = tx_wr && tx_wr_line == 2'(i);
    // 5-bit characters swap the long stop from 2 to 1.5 bits
    assign stop_last = !stop_long[i] ? mux_pkg::STOP1_LAST :
      (len == mux_pkg::LEN5 ? mux_pkg::STOP15_LAST :
      mux_pkg::STOP2_LAST);
    assign hold_v[i] = hv_r;
    assign hold_word[i] = {2'(i), hflag_r[3:0], hd_r};
    assign break_status[i] = brk_r;
    assign serial_out[i] = out_r;
    assign tx_buf_empty[i] = !tbv_r;

    // one generator serves both directions, so speeds always match
    always_comb begin
      bcnt_nxt = tick ? '0 : bcnt_r + 1'b1;
      lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
    end

    always_comb begin
      rst_nxt = rst_r;
      rph_nxt = rph_r;
      rbi_nxt = rbi_r;
      rsh_nxt = rsh_r;
      rpb_nxt = rpb_r;
      hv_nxt = hv_r;
      hd_nxt = hd_r;
      hflag_nxt = hflag_r;
      brk_nxt = brk_r;
      done = 1'b0;
      if (tick) begin
        case (rst_r)
          mux_pkg::RX_IDLE: begin
            if (!lvl_r) begin
              rst_nxt = mux_pkg::RX_START;
              rph_nxt = '0;
            end
          end
          mux_pkg::RX_START: begin
            // recheck at mid start rejects glitches
            if (rph_r == mux_pkg::MID_TICK) begin
              rst_nxt = lvl_r ? mux_pkg::RX_IDLE : mux_pkg::RX_DATA;
              rph_nxt = '0;
              rbi_nxt = '0;
              rsh_nxt = '0;
            end else begin
              rph_nxt = rph_r + 1'b1;
            end
          end
          mux_pkg::RX_DATA: begin
            rph_nxt = rph_r + 1'b1;
            if (rph_r == mux_pkg::LAST_TICK) begin
              rsh_nxt[rbi_r] = lvl_r;
              rbi_nxt = rbi_r + 1'b1;
              if (rbi_r == last) begin
                rst_nxt = parity_en[i] ? mux_pkg::RX_PAR :
                  mux_pkg::RX_STOP;
              end
            end
          end
          mux_pkg::RX_PAR: begin
            rph_nxt = rph_r + 1'b1;
            if (rph_r == mux_pkg::LAST_TICK) begin
              rpb_nxt = lvl_r;
              rst_nxt = mux_pkg::RX_STOP;
            end
          end
          mux_pkg::RX_STOP: begin
            rph_nxt = rph_r + 1'b1;
            // sampled half a bit into the stop bit
            if (rph_r == mux_pkg::LAST_TICK) begin
              done = 1'b1;
              rst_nxt = lvl_r ? mux_pkg::RX_IDLE : mux_pkg::RX_WAIT;
            end
          end
          mux_pkg::RX_WAIT: begin
            if (lvl_r) begin
              rst_nxt = mux_pkg::RX_IDLE;
            end
          end
          default: rst_nxt = mux_pkg::RX_IDLE;
        endcase
      end
      if (lvl_r) begin
        brk_nxt = 1'b0;
      end
      if (take) begin
        hv_nxt = 1'b0;
      end
      if (done) begin
        // overrun is judged before the new character claims the hold
        brk_nxt = !lvl_r && rsh_r == '0 &&
          !(parity_en[i] && rpb_r);
        hflag_nxt = {2'h0, brk_nxt, hv_nxt, !lvl_r,
          parity_en[i] && (^rsh_r ^ rpb_r ^ parity_odd[i])};
        hv_nxt = 1'b1;
        hd_nxt = rsh_r;
      end
      if (!rx_enable[i]) begin
        rst_nxt = mux_pkg::RX_IDLE;
      end
    end

    always_comb begin
      tst_nxt = tst_r;
      tph_nxt = tph_r + 1'b1;
      tbi_nxt = tbi_r;
      tsh_nxt = tsh_r;
      tbuf_nxt = tbuf_r;
      tbv_nxt = tbv_r;
      out_nxt = 1'b1;
      case (tst_r)
        mux_pkg::TX_START: out_nxt = 1'b0;
        mux_pkg::TX_DATA: out_nxt = tsh_r[tbi_r];
        mux_pkg::TX_PAR: out_nxt = ^tsh_r ^ parity_odd[i];
        default: out_nxt = 1'b1;
      endcase
      if (tx_break[i]) begin
        out_nxt = 1'b0;
      end
      if (!tick) begin
        tph_nxt = tph_r;
      end else begin
        case (tst_r)
          mux_pkg::TX_IDLE: begin
            tph_nxt = '0;
            if (tbv_r && tx_enable[i]) begin
              tsh_nxt = tbuf_r & mask;
              tbv_nxt = 1'b0;
              tst_nxt = mux_pkg::TX_START;
            end
          end
          mux_pkg::TX_START: begin
            if (tph_r == mux_pkg::TX_BIT_LAST) begin
              tph_nxt = '0;
              tbi_nxt = '0;
              tst_nxt = mux_pkg::TX_DATA;
            end
          end
          mux_pkg::TX_DATA: begin
            if (tph_r == mux_pkg::TX_BIT_LAST) begin
              tph_nxt = '0;
              tbi_nxt = tbi_r + 1'b1;
              if (tbi_r == last) begin
                tst_nxt = parity_en[i] ? mux_pkg::TX_PAR :
                  mux_pkg::TX_STOP;
              end
            end
          end
          mux_pkg::TX_PAR: begin
            if (tph_r == mux_pkg::TX_BIT_LAST) begin
              tph_nxt = '0;
              tst_nxt = mux_pkg::TX_STOP;
            end
          end
          mux_pkg::TX_STOP: begin
            if (tph_r == stop_last) begin
              tst_nxt = mux_pkg::TX_IDLE;
            end
          end
          default: tst_nxt = mux_pkg::TX_IDLE;
        endcase
      end
      if (wr_hit) begin
        tbuf_nxt = tx_wr_data;
        tbv_nxt = 1'b1;
      end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync_r <= mux_pkg::SYNC_RST;
        lvl_r <= 1'b1;
        bcnt_r <= '0;
        rst_r <= mux_pkg::RX_IDLE;
        rph_r <= '0;
        rbi_r <= '0;
        rsh_r <= '0;
        rpb_r <= 1'b0;
        hv_r <= 1'b0;
        hd_r <= '0;
        hflag_r <= '0;
        brk_r <= 1'b0;
        tst_r <= mux_pkg::TX_IDLE;
        tph_r <= '0;
        tbi_r <= '0;
        tsh_r <= '0;
        tbuf_r <= '0;
        tbv_r <= 1'b0;
        out_r <= 1'b1;
      end else begin
        sync_r <= {sync_r[1:0], serial_in[i]};
        lvl_r <= lvl_nxt;
        bcnt_r <= bcnt_nxt;
        rst_r <= rst_nxt;
        rph_r <= rph_nxt;
        rbi_r <= rbi_nxt;
        rsh_r <= rsh_nxt;
        rpb_r <= rpb_nxt;
        hv_r <= hv_nxt;
        hd_r <= hd_nxt;
        hflag_r <= hflag_nxt;
        brk_r <= brk_nxt;
        tst_r <= tst_nxt;
        tph_r <= tph_nxt;
        tbi_r <= tbi_nxt;
        tsh_r <= tsh_nxt;
        tbuf_r <= tbuf_nxt;
        tbv_r <= tbv_nxt;
        out_r <= out_nxt;
      end
    end

    property p_rx_off;
      !rx_enable[i] |=> rst_r == mux_pkg::RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off)
      else $error("disabled receiver left idle state");

    property p_tx_break;
      tx_break[i] |=> !serial_out[i];
    endproperty
    a_tx_break: assert property (p_tx_break)
      else $error("break command did not hold the line low");
  end

  // ****************************************
  // scanner, silo and interrupts
  // ****************************************
  logic [4:0] pcnt_r, pcnt_nxt;
  logic alarm_r, alarm_nxt, push, rd_ok;
  logic [2:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_lvl_r, sw_lvl_nxt;
  logic halt_nxt, boot_nxt, txi_nxt;
  logic [1:0] txl_nxt;

  rx_silo_fifo #(.WIDTH(mux_pkg::SILO_W), .DEPTH(SILO_DEPTH)) u_silo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .s(silo.fifo)
  );

  assign silo.in_valid = hold_v[scan_r];
  assign silo.in_data = hold_word[scan_r];
  assign silo.out_ready = rbuf_rd;
  assign rbuf_valid = silo.out_valid;
  assign rbuf_data = silo.out_data[7:0];
  assign rbuf_parity_err = silo.out_data[mux_pkg::F_PERR];
  assign rbuf_frame_err = silo.out_data[mux_pkg::F_FERR];
  assign rbuf_overrun = silo.out_data[mux_pkg::F_OVR];
  assign rbuf_break = silo.out_data[mux_pkg::F_BRK];
  assign rbuf_line = silo.out_data[mux_pkg::F_LINE +: 2];
  assign rx_irq = silo_alarm_en ? alarm_r :
    (rx_ie && silo.out_valid);

  always_comb begin
    push = silo.in_valid && silo.in_ready;
    rd_ok = rbuf_rd && silo.out_valid;
    scan_nxt = scan_r + 1'b1;
    pcnt_nxt = pcnt_r;
    alarm_nxt = alarm_r;
    // a read re-arms the alarm; a push in the same cycle still counts
    if (rd_ok) begin
      pcnt_nxt = '0;
      alarm_nxt = 1'b0;
    end
    if (push && pcnt_nxt != mux_pkg::SILO_ALARM_COUNT) begin
      pcnt_nxt = pcnt_nxt + 1'b1;
    end
    if (silo_alarm_en && pcnt_nxt == mux_pkg::SILO_ALARM_COUNT) begin
      alarm_nxt = 1'b1;
    end
    sw_lvl_nxt = sw_lvl_r;
    for (int k = 0; k < 2; k++) begin
      if (sw_s2_r[k] == sw_s3_r[k]) begin
        sw_lvl_nxt[k] = sw_s3_r[k];
      end
    end
    halt_nxt = break_status[3] && sw_lvl_r[0] && !sw_lvl_r[1];
    boot_nxt = break_status[3] && !sw_lvl_r[0] && sw_lvl_r[1];
    txi_nxt = tx_ie && tx_enable[scan_r] && tx_buf_empty[scan_r];
    txl_nxt = scan_r;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_r <= '0;
      pcnt_r <= '0;
      alarm_r <= 1'b0;
      sw_s1_r <= '0;
      sw_s2_r <= '0;
      sw_s3_r <= '0;
      sw_lvl_r <= '0;
      halt_req <= 1'b0;
      boot_req <= 1'b0;
      tx_irq <= 1'b0;
      tx_irq_line <= '0;
    end else begin
      scan_r <= scan_nxt;
      pcnt_r <= pcnt_nxt;
      alarm_r <= alarm_nxt;
      sw_s1_r <= {1'b0, boot_sw, halt_sw};
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
      sw_lvl_r <= sw_lvl_nxt;
      halt_req <= halt_nxt;
      boot_req <= boot_nxt;
      tx_irq <= txi_nxt;
      tx_irq_line <= txl_nxt;
    end
  end

  property p_halt;
    break_status[3] && sw_lvl_r[1:0] == 2'h1 |=> halt_req && !boot_req;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt setting did not raise halt request");

  property p_boot;
    break_status[3] && sw_lvl_r[1:0] == 2'h2 |=> boot_req && !halt_req;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot setting did not raise boot request");

  property p_illegal;
    sw_lvl_r[1:0] == 2'h3 || !break_status[3] |=> !halt_req && !boot_req;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("halt or boot raised without cause");

  property p_rx_done;
    !silo_alarm_en && rx_ie && rbuf_valid |-> rx_irq;
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("receive-done interrupt missing");

  property p_alarm16;
    $rose(alarm_r) |-> $past(pcnt_r) == 5'hf && $past(push);
  endproperty
  a_alarm16: assert property (p_alarm16)
    else $error("silo alarm not on the sixteenth entry");

  property p_rearm;
    rd_ok |=> !alarm_r || pcnt_r == mux_pkg::SILO_ALARM_COUNT;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("silo alarm not re-armed by a read");

  property p_tx_irq;
    tx_irq |-> $past(tx_ie) && tx_buf_empty[tx_irq_line] ||
      $past(tx_wr) && $past(tx_wr_line) == tx_irq_line;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit interrupt without empty buffer");

  property p_scan;
    !$past(sys_rst) |-> scan_r == 2'($past(scan_r) + 2'h1);
  endproperty
  a_scan: assert property (p_scan)
    else $error("scanner left round-robin order");
endmodule
`default_nettype wire

// [verification/term_model.sv]
// terminal-side model of the four serial lines
`timescale 1ns/1ns
`default_nettype none
module term_model (
  input wire logic [3:0] from_dev,
  input wire logic send_break,
  output logic [3:0] to_dev
);
  // ****************************************
  // line levels
  // ****************************************
  // line 0 echoes so one character tests both directions
  always_comb begin
    to_dev[0] = from_dev[0];
    to_dev[2:1] = 2'h3;
    // a break is a long space, held only while commanded
    to_dev[3] = ~send_break;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the four-line serial multiplexer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] rx_enable = 4'h9;
  logic [3:0] tx_enable = 4'h1;
  logic [7:0] char_len = 8'h00;
  logic [3:0] stop_long = 4'h0;
  logic [3:0] parity_en = 4'h1;
  logic [3:0] parity_odd = 4'h1;
  logic [15:0] baud_code = 16'hffff;
  logic [3:0] tx_break = 4'h0;
  logic tx_wr = 1'b0;
  logic [1:0] tx_wr_line = 2'h0;
  logic [7:0] tx_wr_data = 8'h00;
  logic rx_ie = 1'b1;
  logic tx_ie = 1'b1;
  logic silo_alarm_en = 1'b0;
  logic rbuf_rd = 1'b0;
  logic halt_sw = 1'b1;
  logic boot_sw = 1'b0;
  logic send_break = 1'b0;
  logic [3:0] tx_buf_empty, break_status, serial_in, serial_out;
  logic rbuf_valid, rbuf_break, rbuf_overrun, rbuf_frame_err;
  logic rbuf_parity_err, halt_req, boot_req, rx_irq, tx_irq;
  logic [1:0] rbuf_line, tx_irq_line;
  logic [7:0] rbuf_data;
  int err_count = 0;
  int comparisons = 0;
  int n;

  always #5 ref_clk = ~ref_clk;

  quad_async_serial_mux dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .char_len(char_len), .stop_long(stop_long),
    .parity_en(parity_en), .parity_odd(parity_odd),
    .baud_code(baud_code), .tx_break(tx_break), .tx_wr(tx_wr),
    .tx_wr_line(tx_wr_line), .tx_wr_data(tx_wr_data),
    .tx_buf_empty(tx_buf_empty), .rx_ie(rx_ie), .tx_ie(tx_ie),
    .silo_alarm_en(silo_alarm_en), .rbuf_rd(rbuf_rd),
    .rbuf_valid(rbuf_valid), .rbuf_line(rbuf_line),
    .rbuf_data(rbuf_data), .rbuf_break(rbuf_break),
    .rbuf_overrun(rbuf_overrun), .rbuf_frame_err(rbuf_frame_err),
    .rbuf_parity_err(rbuf_parity_err), .break_status(break_status),
    .serial_in(serial_in), .serial_out(serial_out),
    .halt_sw(halt_sw), .boot_sw(boot_sw), .halt_req(halt_req),
    .boot_req(boot_req), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .tx_irq_line(tx_irq_line)
  );

  term_model term (
    .from_dev(serial_out),
    .send_break(send_break),
    .to_dev(serial_in)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check(serial_out, 4'hf);
    check(tx_buf_empty, 4'hf);
    check({rbuf_valid, rx_irq, tx_irq, halt_req, boot_req}, 5'h00);
    $display("test reset done");
    // only line 0 may raise the transmit request
    for (n = 0; n < 32 && tx_irq !== 1'b1; n++) settle();
    check(tx_irq, 1'b1);
    check(tx_irq_line, 2'h0);
    $display("test transmit request done");
    @(posedge ref_clk);
    tx_break <= 4'h2;
    repeat (4) settle();
    check(serial_out, 4'hd);
    $display("test send break done");
    @(posedge ref_clk);
    tx_break <= 4'h0;
    tx_wr <= 1'b1;
    tx_wr_data <= 8'hb5;
    @(posedge ref_clk);
    tx_wr <= 1'b0;
    #1;
    check(tx_buf_empty[0], 1'b0);
    // 5 bits of b5 with odd parity, echoed back into line 0
    for (n = 0; n < 60000 && rbuf_valid !== 1'b1; n++) settle();
    check(rbuf_line, 2'h0);
    check(rbuf_data, 8'h15);
    check({rbuf_parity_err, rbuf_frame_err, rbuf_break}, 3'h0);
    check(rbuf_overrun, 1'b0);
    check(serial_out[1], 1'b1);
    check(tx_buf_empty[0], 1'b1);
    check(rx_irq, 1'b1);
    @(posedge ref_clk);
    silo_alarm_en <= 1'b1;
    repeat (2) settle();
    check(rx_irq, 1'b0);
    @(posedge ref_clk);
    silo_alarm_en <= 1'b0;
    rbuf_rd <= 1'b1;
    @(posedge ref_clk);
    rbuf_rd <= 1'b0;
    repeat (2) settle();
    check({rbuf_valid, rx_irq}, 2'h0);
    $display("test loop character done");
    @(posedge ref_clk);
    send_break <= 1'b1;
    for (n = 0; n < 50000 && break_status[3] !== 1'b1; n++) settle();
    check(break_status, 4'h8);
    repeat (8) settle();
    check({rbuf_valid, rbuf_line, rbuf_break}, 4'hf);
    check({rbuf_frame_err, rbuf_overrun, rbuf_data}, 10'h200);
    // switch order: none, halt only, boot only, both
    for (n = 0; n < 4; n++) begin
      @(posedge ref_clk);
      {boot_sw, halt_sw} <= n[1:0];
      repeat (8) settle();
      check({halt_req, boot_req}, {n == 1, n == 2});
    end
    @(posedge ref_clk);
    send_break <= 1'b0;
    repeat (8) settle();
    check(break_status, 4'h0);
    $display("test break response done");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    #1;
    check({rbuf_valid, tx_buf_empty}, 5'h0f);
    $display("test second reset done");
    conclude();
  end

  initial begin
    #1000000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
